// *** rtl/tsci2c_defs.svh ***
// constants for the touch converter i2c command port
`ifndef TSCI2C_DEFS_SVH
`define TSCI2C_DEFS_SVH

// ============================================================
// address byte
`define TSC_ADDR_PREFIX   5'h12
`define TSC_HS_CODE       5'h01

// ============================================================
// bit positions inside a byte transfer
`define TSC_BIT_ZERO      4'h0
`define TSC_BIT_ONE       4'h1
`define TSC_CH_LAST_BIT   4'h3
`define TSC_SAMPLE_BIT    4'h4
`define TSC_CMD_LAST_BIT  4'h7
`define TSC_BYTE_BITS     4'h8
`define TSC_RES_PAD       4'h0

// ============================================================
// conversion timing
`define TSC_T12_NS        10000
`define TSC_T8_NS         7000
`define TSC_CONV_CLK_NS   160
`define TSC_CONV_CYC_12   (`TSC_T12_NS / `TSC_CONV_CLK_NS)
`define TSC_CONV_CYC_8    (`TSC_T8_NS / `TSC_CONV_CLK_NS)
`define TSC_CNT_LAST      8'h01

`endif

// *** rtl/tsci2c_pkg.sv ***
// types shared by the touch converter i2c command port
package tsci2c_pkg;

  // ============================================================
  // command byte, msb first
  typedef struct packed {
    logic [3:0] channel_config_bits;
    logic       ref_power_select;
    logic       adc_power_select;
    logic       res_8bit;
    logic       ignored;
  } tsci2c_cmd_t;

  // ============================================================
  // serial engine states
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_CMD      = 9'h008,
    ST_CMD_ACK  = 9'h010,
    ST_STRETCH  = 9'h020,
    ST_RD_BYTE  = 9'h040,
    ST_RD_ACK   = 9'h080,
    ST_IGNORE   = 9'h100
  } tsci2c_state_t;

endpackage

// *** rtl/tsci2c_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/10ps
module tsci2c_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // tsci2c_sync

// *** rtl/tsci2c_port.sv ***
// i2c command and readout port of a touch screen converter
//
// Overview of operation
// - power bits set reference, converter, pen enable
// - reference power latched at Stop or Sr
// - adc power bit one keeps drivers on
// - write address acked only on pin match
// - one command byte acked, then Stop or Sr
// - extra command bytes are not acked
// - channel selected after four config bits
// - sampling from scl fall until Stop/Sr
// - mux off at conversion, drivers stay on
// - read address acked, sends result bits 11..4
// - second byte bits 3..0 then four zeros
// - master nacks last; ack repeats result bytes
// - high speed code not acked, ends at Stop
// - scl held low until result loaded
// - address is prefix plus two select pins
// - eight bit result fits one byte
`timescale 1ns/10ps
`include "tsci2c_defs.svh"
module tsci2c_port
  import tsci2c_pkg::*;
#(
  parameter int CONV_CYC_12 = `TSC_CONV_CYC_12,
  parameter int CONV_CYC_8  = `TSC_CONV_CYC_8
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_conv_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_addr_select_hi_pin,
  input  wire logic        i_addr_select_lo_pin,
  input  wire logic [11:0] i_adc_result,
  output logic             o_scl_out,
  output logic             o_scl_oe,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output logic [3:0]       o_channel_config_bits,
  output logic             o_mux_connect,
  output logic             o_x_drv_on,
  output logic             o_y_drv_on,
  output logic             o_ref_power_on,
  output logic             o_pen_touch_interrupt_en,
  output logic             o_hs_mode,
  output logic             o_adc_power_on,
  output logic             o_adc_convert,
  output logic             o_adc_res_8bit
);

  // ============================================================
  // pin synchronisers and bus conditions
  logic [3:0]    pins_s;
  logic          scl_s;
  logic          sda_s;
  logic [1:0]    addr_pins;
  logic          scl_d_q;
  logic          sda_d_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_c;
  logic          stop_c;

  tsci2c_sync #(.W(4)) u_pin_sync (
    .i_clk    (i_sys_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({i_addr_select_hi_pin, i_addr_select_lo_pin, i_sda, i_scl}),
    .o_sync   (pins_s)
  );

  assign scl_s     = pins_s[0];
  assign sda_s     = pins_s[1];
  assign addr_pins = pins_s[3:2];

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_d_q <= 1'h1;
      sda_d_q <= 1'h1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign start_c  = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_c   = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // ============================================================
  // serial engine
  tsci2c_state_t state_q;
  logic [7:0]    shift_q;
  logic [7:0]    tx_q;
  logic [3:0]    bit_q;
  logic          rw_q;
  logic          mack_q;
  logic          byte_sel_q;
  logic [11:0]   res_q;
  logic          conv_pend_q;
  logic          addr_hit;
  logic          hs_hit;
  logic [7:0]    next_byte;

  assign addr_hit  = (shift_q[7:3] == `TSC_ADDR_PREFIX) && (shift_q[2:1] == addr_pins);
  assign hs_hit    = (shift_q[7:3] == `TSC_HS_CODE);
  assign next_byte = byte_sel_q ? {res_q[3:0], `TSC_RES_PAD} : res_q[11:4];

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q    <= ST_IDLE;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      bit_q      <= 4'h0;
      rw_q       <= 1'h0;
      mack_q     <= 1'h0;
      byte_sel_q <= 1'h0;
      o_sda_oe   <= 1'h0;
      o_scl_oe   <= 1'h0;
    end else if (start_c) begin
      state_q  <= ST_ADDR;
      bit_q    <= `TSC_BIT_ZERO;
      o_sda_oe <= 1'h0;
      o_scl_oe <= 1'h0;
    end else if (stop_c) begin
      state_q  <= ST_IDLE;
      o_sda_oe <= 1'h0;
      o_scl_oe <= 1'h0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == `TSC_BYTE_BITS) begin
            if (addr_hit) begin
              state_q  <= ST_ADDR_ACK;
              rw_q     <= shift_q[0];
              o_sda_oe <= 1'h1;
            end else begin
              state_q  <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            o_sda_oe   <= 1'h0;
            bit_q      <= `TSC_BIT_ZERO;
            byte_sel_q <= 1'h0;
            if (!rw_q) begin
              state_q <= ST_CMD;
            end else begin
              // always stretch briefly so data is set up before scl returns
              state_q  <= ST_STRETCH;
              o_scl_oe <= 1'h1;
            end
          end
        end
        ST_CMD: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == `TSC_BYTE_BITS) begin
            state_q  <= ST_CMD_ACK;
            o_sda_oe <= 1'h1;
          end
        end
        ST_CMD_ACK: begin
          if (scl_fall) begin
            state_q  <= ST_IGNORE;
            o_sda_oe <= 1'h0;
          end
        end
        ST_STRETCH: begin
          if (!conv_pend_q && bit_q == `TSC_BIT_ZERO) begin
            o_sda_oe   <= ~next_byte[7];
            tx_q       <= {next_byte[6:0], 1'h0};
            byte_sel_q <= ~byte_sel_q;
            bit_q      <= `TSC_BIT_ONE;
          end else if (bit_q == `TSC_BIT_ONE) begin
            o_scl_oe <= 1'h0;
            state_q  <= ST_RD_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_q == `TSC_BYTE_BITS) begin
              o_sda_oe <= 1'h0;
              bit_q    <= `TSC_BIT_ZERO;
              state_q  <= ST_RD_ACK;
            end else begin
              o_sda_oe <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'h0};
              bit_q    <= bit_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
            bit_q  <= `TSC_BIT_ONE;
          end else if (scl_fall && bit_q == `TSC_BIT_ONE) begin
            if (mack_q) begin
              o_sda_oe   <= ~next_byte[7];
              tx_q       <= {next_byte[6:0], 1'h0};
              byte_sel_q <= ~byte_sel_q;
              state_q    <= ST_RD_BYTE;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ============================================================
  // command capture and acquisition window
  tsci2c_cmd_t cmd_q;
  tsci2c_cmd_t req_q;
  logic        cmd_done_q;
  logic        req_tgl_q;
  logic        done_s;
  logic        done_d_q;
  logic        done_ev;
  logic        in_cmd;

  assign in_cmd = (state_q == ST_CMD);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_q                 <= '0;
      req_q                 <= '0;
      cmd_done_q            <= 1'h0;
      req_tgl_q             <= 1'h0;
      o_mux_connect         <= 1'h0;
      o_channel_config_bits <= 4'h0;
      o_ref_power_on        <= 1'h0;
    end else begin
      if (in_cmd && scl_rise && bit_q == `TSC_CH_LAST_BIT) begin
        o_channel_config_bits <= {shift_q[2:0], sda_s};
      end
      if (in_cmd && scl_fall && bit_q == `TSC_SAMPLE_BIT) begin
        o_mux_connect <= 1'h1;
      end
      if (in_cmd && scl_rise && bit_q == `TSC_CMD_LAST_BIT) begin
        cmd_q      <= {shift_q[6:0], sda_s};
        cmd_done_q <= 1'h1;
      end
      if (start_c || stop_c) begin
        o_mux_connect <= 1'h0;
        cmd_done_q    <= 1'h0;
        if (o_mux_connect && cmd_done_q) begin
          req_q          <= cmd_q;
          req_tgl_q      <= ~req_tgl_q;
          o_ref_power_on <= cmd_q.ref_power_select;
        end
      end
    end
  end

  // ============================================================
  // result handover and pending flag
  logic [11:0] conv_data_q;
  logic        done_tgl_q;

  tsci2c_sync #(.W(1)) u_done_sync (
    .i_clk    (i_sys_clk),
    .i_arst_n (i_arst_n),
    .i_async  (done_tgl_q),
    .o_sync   (done_s)
  );

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_d_q    <= 1'h0;
      conv_pend_q <= 1'h0;
      res_q       <= 12'h000;
    end else begin
      done_d_q <= done_s;
      if (done_ev) begin
        res_q       <= conv_data_q; // held stable by the far side until next toggle
        conv_pend_q <= 1'h0;
      end
      // a new request in the same cycle wins over completion
      if ((start_c || stop_c) && o_mux_connect && cmd_done_q) begin
        conv_pend_q <= 1'h1;
      end
    end
  end

  assign done_ev = done_s ^ done_d_q;

  // ============================================================
  // touch drivers, pen interrupt and high speed flag
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_x_drv_on <= 1'h0;
      o_y_drv_on <= 1'h0;
    end else if (in_cmd && scl_fall && bit_q == `TSC_SAMPLE_BIT) begin
      o_x_drv_on <= o_channel_config_bits[3] &
                    (~o_channel_config_bits[0] | o_channel_config_bits[1]);
      o_y_drv_on <= o_channel_config_bits[3] &
                    (o_channel_config_bits[0] | o_channel_config_bits[1]);
    end else if (done_ev && !req_q.adc_power_select) begin
      o_x_drv_on <= 1'h0;
      o_y_drv_on <= 1'h0;
    end
  end
  // drivers are not touched at conversion start, so they stay on through it

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pen_touch_interrupt_en <= 1'h1;
    end else if (done_ev) begin
      // driver-only commands keep the pen function off whatever the power bits
      o_pen_touch_interrupt_en <= ~req_q.adc_power_select &
                                  ~req_q.channel_config_bits[3];
    end else if (state_q == ST_ADDR_ACK && !rw_q) begin
      o_pen_touch_interrupt_en <= 1'h0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hs_mode <= 1'h0;
    end else if (stop_c) begin
      o_hs_mode <= 1'h0;
    end else if (state_q == ST_ADDR && scl_fall && bit_q == `TSC_BYTE_BITS && hs_hit) begin
      o_hs_mode <= 1'h1;
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_scl_out <= 1'h0;
      o_sda_out <= 1'h0;
    end else begin
      o_scl_out <= 1'h0;
      o_sda_out <= 1'h0;
    end
  end

  // ============================================================
  // conversion sequencer on the converter clock
  logic       req_s;
  logic       req_d_q;
  logic [7:0] cnt_q;

  tsci2c_sync #(.W(1)) u_req_sync (
    .i_clk    (i_conv_clk),
    .i_arst_n (i_arst_n),
    .i_async  (req_tgl_q),
    .o_sync   (req_s)
  );

  always_ff @(posedge i_conv_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_d_q        <= 1'h0;
      done_tgl_q     <= 1'h0;
      cnt_q          <= 8'h00;
      conv_data_q    <= 12'h000;
      o_adc_convert  <= 1'h0;
      o_adc_power_on <= 1'h0;
      o_adc_res_8bit <= 1'h0;
    end else begin
      req_d_q <= req_s;
      if (req_s ^ req_d_q) begin
        // command fields are stable in req_q by the time the toggle lands
        o_adc_convert  <= 1'h1;
        o_adc_power_on <= 1'h1;
        o_adc_res_8bit <= req_q.res_8bit;
        cnt_q <= req_q.res_8bit ? 8'(CONV_CYC_8) : 8'(CONV_CYC_12);
      end else if (o_adc_convert) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == `TSC_CNT_LAST) begin
          o_adc_convert  <= 1'h0;
          o_adc_power_on <= req_q.adc_power_select;
          done_tgl_q     <= ~done_tgl_q;
          conv_data_q    <= o_adc_res_8bit ? {i_adc_result[11:4], `TSC_RES_PAD}
                                           : i_adc_result;
        end
      end
    end
  end

endmodule // tsci2c_port

// *** tb/tsci2c_port_chk.sv ***
// assertion checker for the touch converter i2c port
`timescale 1ns/10ps
module tsci2c_port_chk #(
  parameter int CONV_CYC_12 = 62,
  parameter int CONV_CYC_8  = 43
) (
  input wire logic i_sys_clk,
  input wire logic i_conv_clk,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_x_drv_on,
  input wire logic o_mux_connect,
  input wire logic o_ref_power_on,
  input wire logic o_pen_touch_interrupt_en,
  input wire logic o_hs_mode,
  input wire logic o_adc_convert,
  input wire logic o_adc_res_8bit
);
  // ============================================================
  // line history and saturating cycle counters
  logic       scl_q, sda_q, cnv_q;
  logic [3:0] cond_q, fall_q, done_q;
  logic [7:0] len_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {scl_q, sda_q, cnv_q} <= 3'h6;
      {cond_q, fall_q, done_q} <= 12'hFFF;
    end else begin
      {scl_q, sda_q, cnv_q} <= {i_scl, i_sda, o_adc_convert};
      cond_q <= (i_scl && scl_q && i_sda != sda_q) ? 4'h0 : cond_q + {3'h0, cond_q != 4'hF};
      fall_q <= (scl_q && !i_scl) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
      done_q <= (cnv_q && !o_adc_convert) ? 4'h0 : done_q + {3'h0, done_q != 4'hF};
    end
  end
  // length of the convert pulse, counted where it is made
  always_ff @(posedge i_conv_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      len_q <= 8'h00;
    end else begin
      len_q <= o_adc_convert ? len_q + 8'h01 : 8'h00;
    end
  end
  // ============================================================
  // assertions
  open_drain_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !o_scl_out && !o_sda_out) else $error("pin driven high");
  sda_change_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $changed(o_sda_oe) |-> !i_scl) else $error("sda moved while scl high");
  ref_latch_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $changed(o_ref_power_on) |-> cond_q <= 4'h8) else $error("ref changed off stop");
  sample_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(o_mux_connect) |-> fall_q <= 4'h6 && !i_scl) else $error("sampling began late");
  sample_end_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $fell(o_mux_connect) |-> cond_q <= 4'h8) else $error("sampling ended off stop");
  mux_conv_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_adc_convert |-> !o_mux_connect) else $error("mux on in conversion");
  drv_on_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(o_x_drv_on) |-> o_mux_connect) else $error("driver on outside sampling");
  stretch_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_scl_oe && o_adc_convert |=> o_scl_oe) else $error("scl freed in conversion");
  hs_exit_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $fell(o_hs_mode) |-> cond_q <= 4'h8) else $error("hs left off stop");
  pen_done_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(o_pen_touch_interrupt_en) |-> done_q <= 4'h8) else $error("pen on off done");
  conv_len_a: assert property (@(posedge i_conv_clk) disable iff (!i_arst_n)
    $fell(o_adc_convert) |-> len_q == (o_adc_res_8bit ? CONV_CYC_8 : CONV_CYC_12))
    else $error("conversion length wrong");
  stretch_c: cover property (@(posedge i_sys_clk) $rose(o_scl_oe));
  hs_c: cover property (@(posedge i_sys_clk) $rose(o_hs_mode));
  conv_c: cover property (@(posedge i_conv_clk) $fell(o_adc_convert) && o_adc_res_8bit);
endmodule // tsci2c_port_chk

bind tsci2c_port tsci2c_port_chk #(.CONV_CYC_12(CONV_CYC_12), .CONV_CYC_8(CONV_CYC_8)) u_chk (
  .i_sys_clk(i_sys_clk), .i_conv_clk(i_conv_clk), .i_arst_n(i_arst_n), .i_scl(i_scl),
  .i_sda(i_sda), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_x_drv_on(o_x_drv_on), .o_mux_connect(o_mux_connect),
  .o_ref_power_on(o_ref_power_on), .o_pen_touch_interrupt_en(o_pen_touch_interrupt_en),
  .o_hs_mode(o_hs_mode), .o_adc_convert(o_adc_convert), .o_adc_res_8bit(o_adc_res_8bit));

// *** tb/tsci2c_i2c_master.sv ***
// behavioural i2c bus master pulling the shared lines
`timescale 1ns/10ps
module tsci2c_i2c_master (
  input  wire logic i_sys_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_pull,
  output logic      o_sda_pull
);
  initial begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
  end
  task automatic hp();
    repeat (8) @(posedge i_sys_clk);
  endtask
  // start from idle or repeated start after a low clock
  task automatic start();
    o_sda_pull <= 1'b0;
    hp();
    o_scl_pull <= 1'b0;
    hp();
    o_sda_pull <= 1'b1;
    hp();
    o_scl_pull <= 1'b1;
  endtask
  task automatic stop();
    o_sda_pull <= 1'b1;
    hp();
    o_scl_pull <= 1'b0;
    hp();
    o_sda_pull <= 1'b0;
    hp();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    int n;
    n = 0;
    o_sda_pull <= !b;
    hp();
    o_scl_pull <= 1'b0;
    @(posedge i_sys_clk);
    // the slave may hold the clock low
    while (!i_scl && n < 4000) begin
      @(posedge i_sys_clk);
      n++;
    end
    hp();
    r = i_sda;
    o_scl_pull <= 1'b1;
    // hold data past the fall so it never reads as start or stop
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(!ack, r);
  endtask
endmodule // tsci2c_i2c_master

// *** tb/tb_tsci2c_port.sv ***
// self-checking bench for the touch converter i2c port
`timescale 1ns/10ps
`include "tsci2c_defs.svh"
module tb_tsci2c_port
  import tsci2c_pkg::*;
;
  // full length, so a read straight after Sr really has to be stretched
  localparam int C12 = `TSC_CONV_CYC_12;
  localparam int C8  = `TSC_CONV_CYC_8;
  logic        sys_clk, conv_clk, arst_n, a_hi, a_lo, a, ref_exp;
  logic        scl_oe, sda_oe, m_scl, m_sda, hs, mux, xd, yd, refp, pen, apw, conv, r8;
  logic [3:0]  chan;
  logic [11:0] adc_res;
  tsci2c_cmd_t c;
  int          num_errors, check_count, seed;
  wire         scl = !(scl_oe || m_scl);
  wire         sda = !(sda_oe || m_sda);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = !sys_clk;
  end
  initial begin
    conv_clk = 1'b0;
    #7.3;
    forever #80 conv_clk = !conv_clk;
  end

  tsci2c_port #(.CONV_CYC_12(C12), .CONV_CYC_8(C8)) dut (
    .i_sys_clk(sys_clk), .i_conv_clk(conv_clk), .i_arst_n(arst_n), .i_scl(scl),
    .i_sda(sda), .i_addr_select_hi_pin(a_hi), .i_addr_select_lo_pin(a_lo),
    .i_adc_result(adc_res), .o_scl_out(), .o_scl_oe(scl_oe), .o_sda_out(),
    .o_sda_oe(sda_oe), .o_channel_config_bits(chan), .o_mux_connect(mux),
    .o_x_drv_on(xd), .o_y_drv_on(yd), .o_ref_power_on(refp),
    .o_pen_touch_interrupt_en(pen), .o_hs_mode(hs), .o_adc_power_on(apw),
    .o_adc_convert(conv), .o_adc_res_8bit(r8));
  tsci2c_i2c_master m (.i_sys_clk(sys_clk), .i_scl(scl), .i_sda(sda),
    .o_scl_pull(m_scl), .o_sda_pull(m_sda));

  // ============================================================
  // expectations and checks
  function automatic logic [1:0] drv_exp(input logic [3:0] ch);
    return ch[3] ? (ch[1] ? 2'b11 : {!ch[0], ch[0]}) : 2'b00;
  endfunction
  function automatic logic [7:0] byte_exp(input logic [11:0] r, input logic m8, input logic s);
    return s ? (m8 ? 8'h00 : {r[3:0], 4'h0}) : r[11:4];
  endfunction
  task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_conv(input logic v);
    int n;
    n = 0;
    while (conv !== v && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    check("convert", v, conv);
  endtask

  // ============================================================
  // transfers
  task automatic wr_cmd(input tsci2c_cmd_t k, input logic extra, input logic sr);
    m.start();
    m.wr({`TSC_ADDR_PREFIX, a_hi, a_lo, 1'b0}, a);
    check("addr ack", 1, a);
    m.wr(k, a);
    check("cmd ack", 1, a);
    check("channel", k.channel_config_bits, chan);
    check("sampling", 1, mux);
    check("drivers", drv_exp(k.channel_config_bits), {xd, yd});
    check("pen off", 0, pen);
    check("ref hold", ref_exp, refp);
    if (extra) begin
      m.wr(8'($random(seed)), a);
      check("extra ack", 0, a);
    end
    ref_exp = k.ref_power_select;
    if (!sr) begin
      m.stop();
      repeat (6) @(posedge sys_clk);
      check("sampling end", 0, mux);
      check("ref latch", ref_exp, refp);
    end
  endtask
  task automatic after_conv(input tsci2c_cmd_t k);
    wait_conv(1'b1);
    check("res mode", k.res_8bit, r8);
    check("mux conv", 0, mux);
    check("drv conv", drv_exp(k.channel_config_bits), {xd, yd});
    wait_conv(1'b0);
    repeat (20) @(posedge sys_clk);
    check("adc power", k.adc_power_select, apw);
    check("drv after", k.adc_power_select ? drv_exp(k.channel_config_bits) : 2'b00, {xd, yd});
    if (!k.channel_config_bits[3]) check("pen", !k.adc_power_select, pen);
  endtask
  task automatic rd_res(input logic [11:0] r, input logic m8);
    logic [7:0] d;
    m.start();
    m.wr({`TSC_ADDR_PREFIX, a_hi, a_lo, 1'b1}, a);
    check("read ack", 1, a);
    for (int k = 0; k < 4; k++) begin
      m.rd(k < 3, d);
      check("result", byte_exp(r, m8, k[0]), d);
    end
    m.stop();
  endtask

  // ============================================================
  // main sequence
  initial begin
    seed = 32'h3319;
    num_errors = 0;
    check_count = 0;
    ref_exp = 1'b0;
    arst_n = 1'b0;
    {a_hi, a_lo} = 2'h0;
    adc_res = 12'h000;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    {a_hi, a_lo} <= 2'($random(seed));
    repeat (6) @(posedge sys_clk);
    m.start();
    m.wr({`TSC_ADDR_PREFIX, !a_hi, a_lo, 1'b0}, a);
    check("foreign ack", 0, a);
    m.stop();
    c = '0;
    wr_cmd(c, 1'b0, 1'b0);
    after_conv(c);
    for (int i = 0; i < 8; i++) begin
      c = 8'($random(seed));
      if (c.channel_config_bits[3:2] == 2'b10) c.channel_config_bits[2] = 1'b1;
      if (i == 7) c.ref_power_select = 1'b0;
      adc_res <= 12'($random(seed));
      wr_cmd(c, i[0], i == 3);
      if (i == 3) begin
        rd_res(adc_res, c.res_8bit);
      end else begin
        after_conv(c);
        repeat (400) @(posedge sys_clk);
        rd_res(adc_res, c.res_8bit);
      end
    end
    m.start();
    m.wr({`TSC_HS_CODE, 3'($random(seed))}, a);
    check("hs ack", 0, a);
    check("hs mode", 1, hs);
    c = '0;
    wr_cmd(c, 1'b0, 1'b0);
    check("hs exit", 0, hs);
    after_conv(c);
    test_done();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
endmodule // tb_tsci2c_port
